/* File: ocd_pkg.sv */
// constants for the output channel divider block
package ocd_pkg;
    localparam int unsigned N_CHAN = 3;
    localparam int unsigned N_REGS = 9;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CHAN0_DIVIDER_CYCLES = 10'h190;
    localparam logic [9:0] IDX_CHAN0_DIVIDER_CONTROL = 10'h191;
    localparam logic [9:0] IDX_CHAN0_POWER_AND_DCC = 10'h192;
    localparam logic [9:0] IDX_CHAN1_DIVIDER_CYCLES = 10'h193;
    localparam logic [9:0] IDX_CHAN1_DIVIDER_CONTROL = 10'h194;
    localparam logic [9:0] IDX_CHAN1_POWER_AND_DCC = 10'h195;
    localparam logic [9:0] IDX_CHAN2_DIVIDER_CYCLES = 10'h196;
    localparam logic [9:0] IDX_CHAN2_DIVIDER_CONTROL = 10'h197;
    localparam logic [9:0] IDX_CHAN2_POWER_AND_DCC = 10'h198;
    localparam logic [9:0] IDX_BASE = IDX_CHAN0_DIVIDER_CYCLES;
    // cycles register fields
    localparam int unsigned LOW_MSB = 7;
    localparam int unsigned LOW_LSB = 4;
    localparam int unsigned HIGH_MSB = 3;
    localparam int unsigned HIGH_LSB = 0;
    // control register fields
    localparam int unsigned BIT_BYPASS = 7;
    localparam int unsigned BIT_IGNORE_RESYNC = 6;
    localparam int unsigned BIT_FORCE_LEVEL = 5;
    localparam int unsigned BIT_START_HIGH = 4;
    localparam int unsigned PHASE_MSB = 3;
    localparam int unsigned PHASE_LSB = 0;
    // power register fields
    localparam int unsigned BIT_POWER_DOWN = 2;
    localparam int unsigned BIT_DCC_DISABLE = 0;
    localparam logic [7:0] POWER_WMASK = 8'h05;
    // reset values
    localparam logic [7:0] RST_CHAN0_CYCLES = 8'h77;
    localparam logic [7:0] RST_CHAN1_CYCLES = 8'h33;
    localparam logic [7:0] RST_CHAN2_CYCLES = 8'h11;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;
    // ahb-lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* File: ocd_divider.sv */
// output channel dividers with ahb-lite register slave
// Contract
// RL1 - output stays low for low-cycles field plus one input cycles
// RL2 - output stays high for high-cycles field plus one input cycles
// RL3 - channel 1 fields reset to three, channel 2 fields reset to one
// RL4 - bypass bit passes input clock to output, divider idle; zero uses divider
// RL5 - ignore-resync zero obeys the resync signal, one disregards it
// RL6 - force-level acts only while ignore-resync also set; software sets both
// RL7 - force-level has no effect while the divider is bypassed
// RL8 - forced output: zero holds low, one holds high
// RL9 - start-level bit picks initial output level, zero low, one high
// RL10 - four-bit phase offset field per divider, resets to zero
// RL11 - power-down bit puts the channel's three output pairs in high impedance
// RL12 - duty-cycle correction active when disable bit is zero
// RL13 - channel 0 fields reset to seven, eight cycles low and high
// RL14 - obeyed resync restarts at start level after phase offset cycles
// RL15 - count changes take effect at phase boundaries, no runt pulses
`timescale 1ns/1ps
module ocd_divider (
    input wire logic hclk, // bus and divider input clock
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic resync, // chip-wide resynchronisation pulse
    output logic [2:0] chan_out, // divider outputs, one per channel
    output logic output_pair_zero_en, // pair driven when high
    output logic output_pair_one_en, // pair driven when high
    output logic output_pair_two_en, // pair driven when high
    output logic output_pair_three_en, // pair driven when high
    output logic output_pair_four_en, // pair driven when high
    output logic output_pair_five_en, // pair driven when high
    output logic [2:0] chan2_pairs_en, // channel 2 pairs driven when high
    output logic [2:0] duty_cycle_correction // correction active per channel
);
    logic [7:0] regs [ocd_pkg::N_REGS];
    logic wr_pend;
    logic [3:0] wr_idx;
    logic wr_hit;

    function automatic logic [7:0] reset_value(input int unsigned idx);
        case (idx)
            0: reset_value = ocd_pkg::RST_CHAN0_CYCLES; // RL13
            3: reset_value = ocd_pkg::RST_CHAN1_CYCLES; // RL3
            6: reset_value = ocd_pkg::RST_CHAN2_CYCLES; // RL3
            1, 4, 7: reset_value = ocd_pkg::RST_CONTROL; // RL10
            default: reset_value = ocd_pkg::RST_POWER;
        endcase
    endfunction

    function automatic logic [7:0] write_mask(input int unsigned idx);
        // power registers keep only the two defined bits
        write_mask = (idx % 3 == 2) ? ocd_pkg::POWER_WMASK : 8'hff;
    endfunction

    // phase counts held in a cycles register
    function automatic logic [3:0] low_count(input logic [7:0] cycles);
        low_count = cycles[ocd_pkg::LOW_MSB:ocd_pkg::LOW_LSB];
    endfunction

    function automatic logic [3:0] high_count(input logic [7:0] cycles);
        high_count = cycles[ocd_pkg::HIGH_MSB:ocd_pkg::HIGH_LSB];
    endfunction

    function automatic int unsigned cycles_index(input int unsigned chan);
        cycles_index = 3 * chan;
    endfunction

    function automatic int unsigned control_index(input int unsigned chan);
        control_index = 3 * chan + 1;
    endfunction

    function automatic int unsigned power_index(input int unsigned chan);
        power_index = 3 * chan + 2;
    endfunction

    function automatic logic start_level(input logic [7:0] control);
        start_level = control[ocd_pkg::BIT_START_HIGH];
    endfunction

    // divider sequencing: count off the phase offset, then run
    typedef enum logic {
        DIV_DELAY = 1'b0,
        DIV_RUN = 1'b1
    } ocd_div_state_t;

    function automatic logic decode(input logic [31:0] addr, output logic [3:0] idx);
        logic [9:0] word;
        logic [9:0] off;
        word = addr[11:2];
        off = word - ocd_pkg::IDX_BASE;
        idx = off[3:0];
        // unmapped words read zero and drop writes
        decode = (addr[31:12] == 20'h00000) && (word >= ocd_pkg::IDX_BASE)
            && (off < 10'(ocd_pkg::N_REGS));
    endfunction

    // address phase
    logic take;
    logic a_hit;
    logic [3:0] a_idx;
    always_comb begin
        take = hsel && htrans[1] && hready;
        a_hit = decode(haddr, a_idx);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
        end else begin
            wr_pend <= take && hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_idx <= 4'h0;
        end else begin
            wr_idx <= a_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_hit <= 1'b0;
        end else begin
            wr_hit <= a_hit;
        end
    end

    // zero wait states; read data sampled in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            hrdata <= a_hit ? {24'h000000, regs[a_idx]} : 32'h00000000;
        end
    end

    // no wait states: every register answers within one data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    genvar r;
    generate
        for (r = 0; r < ocd_pkg::N_REGS; r++) begin : g_reg
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    regs[r] <= reset_value(r);
                end else if (wr_pend && wr_hit && wr_idx == 4'(r)) begin
                    regs[r] <= hwdata[7:0] & write_mask(r);
                end
            end
        end
    endgenerate

    // per-channel divider
    genvar c;
    generate
        for (c = 0; c < ocd_pkg::N_CHAN; c++) begin : g_chan
            logic [7:0] cyc;
            logic [7:0] ctl;
            logic [7:0] pwr;
            logic lvl;
            logic [3:0] cnt;
            logic [3:0] lo_q;
            logic [3:0] hi_q;
            ocd_div_state_t st;
            logic [3:0] dly;
            logic byp_tgl;
            logic obey;
            logic [3:0] limit;
            always_comb begin
                cyc = regs[cycles_index(c)];
                ctl = regs[control_index(c)];
                pwr = regs[power_index(c)];
                // a resync held high keeps the divider restarting
                obey = resync && !ctl[ocd_pkg::BIT_IGNORE_RESYNC]; // RL5
                limit = lvl ? hi_q : lo_q;
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    lvl <= 1'b0;
                    cnt <= 4'h0;
                    lo_q <= 4'h0;
                    hi_q <= 4'h0;
                    st <= DIV_DELAY;
                    dly <= 4'h0;
                end else if (ctl[ocd_pkg::BIT_BYPASS]) begin
                    // divider idle while bypassed; restart cleanly afterwards
                    lvl <= start_level(ctl); // RL4
                    st <= DIV_DELAY;
                    dly <= 4'h0;
                end else if (obey) begin
                    lvl <= start_level(ctl); // RL14
                    st <= DIV_DELAY;
                    dly <= ctl[ocd_pkg::PHASE_MSB:ocd_pkg::PHASE_LSB]; // RL14
                end else begin
                    case (st)
                        DIV_DELAY: begin
                            if (dly == 4'h0) begin
                                st <= DIV_RUN;
                                cnt <= 4'h0;
                                lvl <= start_level(ctl); // RL9
                                lo_q <= low_count(cyc);
                                hi_q <= high_count(cyc);
                            end else begin
                                dly <= dly - 4'h1;
                            end
                        end
                        DIV_RUN: begin
                            if (cnt == limit) begin
                                // new counts are picked up only at a phase edge
                                lvl <= !lvl; // RL1 RL2
                                cnt <= 4'h0;
                                lo_q <= low_count(cyc); // RL15
                                hi_q <= high_count(cyc); // RL15
                            end else begin
                                cnt <= cnt + 4'h1;
                            end
                        end
                        default: begin
                            st <= DIV_DELAY;
                        end
                    endcase
                end
            end

            // bypass image of the input clock: toggles every cycle
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    byp_tgl <= 1'b0;
                end else begin
                    byp_tgl <= ctl[ocd_pkg::BIT_BYPASS] ? !byp_tgl : 1'b0;
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    chan_out[c] <= 1'b0;
                end else if (ctl[ocd_pkg::BIT_BYPASS]) begin
                    chan_out[c] <= !byp_tgl; // RL4 RL7
                end else if (ctl[ocd_pkg::BIT_IGNORE_RESYNC] && ctl[ocd_pkg::BIT_FORCE_LEVEL] == 1'b1) begin
                    // forcing needs ignore-resync; the count runs on underneath
                    chan_out[c] <= 1'b1; // RL6 RL8
                end else if (ctl[ocd_pkg::BIT_IGNORE_RESYNC] && ctl[ocd_pkg::BIT_FORCE_LEVEL] == 1'b0) begin
                    chan_out[c] <= 1'b0; // RL6 RL8
                end else begin
                    chan_out[c] <= lvl;
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    duty_cycle_correction[c] <= 1'b1;
                end else begin
                    duty_cycle_correction[c] <= !pwr[ocd_pkg::BIT_DCC_DISABLE]; // RL12
                end
            end
        end
    endgenerate

    // three pairs per channel follow the channel's power-down, one cycle after the write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_pair_zero_en <= 1'b1;
            output_pair_one_en <= 1'b1;
            output_pair_two_en <= 1'b1;
            output_pair_three_en <= 1'b1;
            output_pair_four_en <= 1'b1;
            output_pair_five_en <= 1'b1;
            chan2_pairs_en <= 3'h7;
        end else begin
            output_pair_zero_en <= !regs[power_index(0)][ocd_pkg::BIT_POWER_DOWN]; // RL11
            output_pair_one_en <= !regs[power_index(0)][ocd_pkg::BIT_POWER_DOWN];
            output_pair_two_en <= !regs[power_index(0)][ocd_pkg::BIT_POWER_DOWN];
            output_pair_three_en <= !regs[power_index(1)][ocd_pkg::BIT_POWER_DOWN]; // RL11
            output_pair_four_en <= !regs[power_index(1)][ocd_pkg::BIT_POWER_DOWN];
            output_pair_five_en <= !regs[power_index(1)][ocd_pkg::BIT_POWER_DOWN];
            chan2_pairs_en <= {3{!regs[power_index(2)][ocd_pkg::BIT_POWER_DOWN]}};
        end
    end
endmodule

/* File: ocd_divider_properties.sv */
// port-level assertions for the output channel dividers
`timescale 1ns/1ps
module ocd_chk (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // ready
    input wire logic resync, // resync
    input wire logic [2:0] chan_out, // divider outputs
    input wire logic output_pair_zero_en, // group 0
    input wire logic output_pair_one_en, // group 0
    input wire logic output_pair_two_en, // group 0
    input wire logic output_pair_three_en, // group 1
    input wire logic output_pair_four_en, // group 1
    input wire logic output_pair_five_en, // group 1
    input wire logic [2:0] chan2_pairs_en, // group 2
    input wire logic [2:0] duty_cycle_correction // correction
);
    logic wq;
    logic [31:0] aq;
    logic [7:0] ctl;
    // mirror of channel 0 control, lands on the same edge as the design's
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wq <= 1'b0;
            aq <= 32'h0;
            ctl <= 8'h00;
        end else begin
            wq <= hsel && htrans[1] && hready && hwrite;
            aq <= haddr;
            if (wq && aq == 32'h644) ctl <= hwdata[7:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence wr_data(logic [31:0] a);
        wq && aq == a;
    endsequence
    chk_pd_group0: assert property (wr_data(32'h648) |-> ##2 output_pair_zero_en == !$past(hwdata[2], 2))
        else $error("power-down of group 0 not followed");
    chk_dcc_one: assert property (wr_data(32'h654) |-> ##2 duty_cycle_correction[1] == !$past(hwdata[0], 2))
        else $error("duty cycle correction 1 wrong");
    chk_group_zero: assert property (output_pair_zero_en == output_pair_one_en && output_pair_one_en == output_pair_two_en)
        else $error("group 0 pairs differ");
    chk_group_one: assert property (output_pair_three_en == output_pair_four_en && output_pair_four_en == output_pair_five_en)
        else $error("group 1 pairs differ");
    chk_group_two: assert property (chan2_pairs_en == 3'h0 || chan2_pairs_en == 3'h7)
        else $error("group 2 pairs differ");
    chk_force_level: assert property (ctl[6] && !ctl[7] |=> chan_out[0] == $past(ctl[5]))
        else $error("forced level wrong");
    chk_bypass_toggle: assert property (ctl[7] [*3] |-> chan_out[0] != $past(chan_out[0]))
        else $error("bypass output not toggling");
    chk_resync_start: assert property (resync && !ctl[6] && !ctl[7] |-> ##2 chan_out[0] == $past(ctl[4], 2))
        else $error("resync did not restart at start level");
endmodule

/* File: test_ocd_divider.sv */
// self-checking bench for the output channel dividers
`timescale 1ns/1ps
module test_ocd_divider;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, resync = 1'b0, rd_dp = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = ocd_pkg::HSIZE_WORD, chan_out, c2en, dcc;
    logic hreadyout, hresp, e0, e1, e2, e3, e4, e5;
    logic [31:0] expq[$];
    logic [7:0] rst_tab[9] = '{8'h77, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00};
    int err_total = 0, check_count = 0, n;
    always #10 hclk = ~hclk;
    ocd_divider ocd_divider_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .resync(resync), .chan_out(chan_out),
        .output_pair_zero_en(e0), .output_pair_one_en(e1), .output_pair_two_en(e2),
        .output_pair_three_en(e3), .output_pair_four_en(e4), .output_pair_five_en(e5),
        .chan2_pairs_en(c2en), .duty_cycle_correction(dcc));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= ocd_pkg::HTRANS_NONSEQ;
        hsize <= ocd_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        expq.push_back({24'h0, e});
        xfer(a, 1'b0, 8'h00);
    endtask
    // length of the next full run of level lvl on channel c
    task automatic span(input int c, input logic lvl, output int k);
        k = 0;
        for (int i = 0; i < 99 && chan_out[c] === lvl; i++) @(posedge hclk);
        for (int i = 0; i < 99 && chan_out[c] !== lvl; i++) @(posedge hclk);
        for (int i = 0; i < 99 && chan_out[c] === lvl; i++) begin
            @(posedge hclk);
            k++;
        end
    endtask
    // watcher: compares read data against the oldest note
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1 && expq.size() > 0) check(hrdata, expq.pop_front());
        rd_dp = hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    initial begin
        void'($urandom(32'h61b8));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 10; i++) rd(32'h640 + 4 * i, i < 9 ? rst_tab[i] : 8'h00);
        span(0, 1'b0, n); check(n, 8);
        span(0, 1'b1, n); check(n, 8);
        span(2, 1'b1, n); check(n, 2);
        v = $urandom;
        xfer(32'h64c, 1'b1, v[7:0]);
        rd(32'h64c, v[7:0]);
        repeat (40) @(posedge hclk);
        span(1, 1'b0, n); check(n, v[7:4] + 1);
        span(1, 1'b1, n); check(n, v[3:0] + 1);
        xfer(32'h644, 1'b1, 8'h20);
        span(0, 1'b1, n); check(n, 8);
        for (int f = 0; f < 2; f++) begin
            xfer(32'h644, 1'b1, f ? 8'h60 : 8'h40);
            repeat (3) @(posedge hclk);
            check(chan_out[0], f);
        end
        xfer(32'h644, 1'b1, 8'he0);
        span(0, 1'b1, n); check(n, 1);
        for (int g = 0; g < 2; g++) begin
            xfer(32'h644, 1'b1, g ? 8'h53 : 8'h13);
            span(0, 1'b0, n);
            for (int i = 0; i < 99 && chan_out[0] !== 1'b0; i++) @(posedge hclk);
            resync <= 1'b1;
            @(posedge hclk);
            resync <= 1'b0;
            repeat (2) @(posedge hclk);
            check(chan_out[0], !g);
        end
        xfer(32'h648, 1'b1, 8'h04);
        xfer(32'h654, 1'b1, 8'h01);
        xfer(32'h660, 1'b1, 8'hff);
        rd(32'h660, ocd_pkg::POWER_WMASK);
        repeat (2) @(posedge hclk);
        check({e0, e1, e2, e3, e4, e5, c2en}, 9'h038);
        check(dcc, 3'h1);
        @(posedge hclk);
        summarize();
    end
endmodule
bind ocd_divider ocd_chk ocd_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .resync(resync),
    .chan_out(chan_out), .output_pair_zero_en(output_pair_zero_en), .output_pair_one_en(output_pair_one_en),
    .output_pair_two_en(output_pair_two_en), .output_pair_three_en(output_pair_three_en),
    .output_pair_four_en(output_pair_four_en), .output_pair_five_en(output_pair_five_en),
    .chan2_pairs_en(chan2_pairs_en), .duty_cycle_correction(duty_cycle_correction));
